//--- erpb_pkg.sv
// Constants for the root port bridge configuration block
package erpb_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0]  OFF_DSTAT  = 8'h1e;
	localparam logic [7:0]  OFF_MWIN   = 8'h20;
	localparam logic [7:0]  OFF_PWIN   = 8'h24;
	localparam logic [7:0]  OFF_PLOUP  = 8'h28;
	localparam logic [7:0]  OFF_PHIUP  = 8'h2c;
	localparam logic [7:0]  OFF_CAPPTR = 8'h34;
	localparam logic [7:0]  OFF_IRQ    = 8'h3c;
	localparam logic [7:0]  OFF_BRCTL  = 8'h3e;
	localparam logic [7:0]  OFF_CAPHD  = 8'h40;
	localparam logic [7:0]  OFF_XPCAP  = 8'h42;
	localparam logic [7:0]  OFF_DEVCAP = 8'h44;
	localparam logic [5:0]  DW_DSTAT   = OFF_DSTAT[7:2];
	localparam logic [5:0]  DW_MWIN    = OFF_MWIN[7:2];
	localparam logic [5:0]  DW_PWIN    = OFF_PWIN[7:2];
	localparam logic [5:0]  DW_PLOUP   = OFF_PLOUP[7:2];
	localparam logic [5:0]  DW_PHIUP   = OFF_PHIUP[7:2];
	localparam logic [5:0]  DW_CAPPTR  = OFF_CAPPTR[7:2];
	localparam logic [5:0]  DW_IRQ     = OFF_IRQ[7:2];
	localparam logic [5:0]  DW_CAPHD   = OFF_CAPHD[7:2];
	localparam logic [5:0]  DW_DEVCAP  = OFF_DEVCAP[7:2];
	// ****************************************
	// Field positions, masks and values
	// ****************************************
	localparam int          FLG_N      = 6;
	localparam int          FLG_PPAR   = 0;
	localparam int          FLG_CATX   = 1;
	localparam int          FLG_CARX   = 2;
	localparam int          FLG_URRX   = 3;
	localparam int          FLG_ERRX   = 4;
	localparam int          FLG_PSRX   = 5;
	localparam int          BC_PSNREP  = 0;
	localparam int          BC_ERRFWD  = 1;
	localparam int          BC_ISABLK  = 2;
	localparam int          BC_VGA     = 3;
	localparam int          BC_NOALIAS = 4;
	localparam int          BC_HOTRST  = 6;
	localparam int          XPCAP_SLOT = 8;
	localparam logic [15:0] BRCTL_WMASK = 16'h005f;
	localparam logic [15:0] BRCTL_RST   = 16'h0000;
	localparam logic [31:0] WIN_WMASK   = 32'hfff0fff0;
	localparam logic [31:0] PWIN_RO     = 32'h00010001;
	localparam logic [7:0]  CAPPTR_VAL  = 8'h40;
	localparam logic [15:0] CAPHD_VAL   = 16'h8010;
	localparam logic [15:0] XPCAP_RST   = 16'h0041;
	localparam logic [31:0] DEVCAP_VAL  = 32'h00000fc0;
	localparam logic [46:0] VGA_MEM_TAG = 47'h5;
	localparam logic [9:0]  VGA_IOA_LO  = 10'h3b0;
	localparam logic [9:0]  VGA_IOA_HI  = 10'h3bb;
	localparam logic [9:0]  VGA_IOB_LO  = 10'h3c0;
	localparam logic [9:0]  VGA_IOB_HI  = 10'h3df;
	localparam logic [1:0]  SEV_COR     = 2'h0;
endpackage : erpb_pkg

//--- erpb_win_if.sv
// Window compare signals between the register file and the comparator
`timescale 1ns/1ps
interface erpb_win_if;
	logic [43:0] base;
	logic [43:0] limit;
	logic [63:0] addr_dn;
	logic [63:0] addr_up;
	logic        hit_dn;
	logic        hit_up;
	modport ctl (output base, output limit, output addr_dn, output addr_up, input hit_dn, input hit_up);
	modport cmp (input base, input limit, input addr_dn, input addr_up, output hit_dn, output hit_up);
endinterface : erpb_win_if

//--- erpb_win.sv
// Inclusive 1-MB granular window compare over a 64-bit address
`timescale 1ns/1ps
module erpb_win (
	erpb_win_if.cmp w
);
	function automatic logic in_win(input logic [63:0] a, input logic [43:0] b, input logic [43:0] l);
		in_win = (a[63:20] >= b) && (a[63:20] <= l);
	endfunction : in_win

	assign w.hit_dn = in_win(w.addr_dn, w.base, w.limit);
	assign w.hit_up = in_win(w.addr_up, w.base, w.limit);
endmodule : erpb_win

//--- erpb_flags.sv
// Sticky write-one-to-clear flags where a set beats a clear
`timescale 1ns/1ps
module erpb_flags #(
	parameter int N = 6
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [N-1:0] set_i,
	input  wire logic [N-1:0] clr_i,
	output logic      [N-1:0] flags_o
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_o <= '0;
		end else begin
			flags_o <= (flags_o & ~clr_i) | set_i;
		end
	end

	property p_set_wins;
		@(posedge clk_i) disable iff (rst_i)
		(set_i != '0) |=> ((flags_o & $past(set_i)) == $past(set_i));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("flag set lost");

	property p_clear;
		@(posedge clk_i) disable iff (rst_i)
		(clr_i != '0) |=> ((flags_o & $past(clr_i) & ~$past(set_i)) == '0);
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared");
endmodule : erpb_flags

//--- erpb_cfg.sv
// Bridge header configuration registers and forwarding decode of a root port
`timescale 1ns/1ps
// How it works
// - Poisoned packet received sets flag 15
// - Fatal or non-fatal message sets flag 14
// - Unsupported request completion sets flag 13
// - Completer abort completion received sets flag 12
// - Completer abort sent sets flag 11
// - Flag 8 only with poison reporting enabled
// - Status flags write-one-clear, zero after reset
// - Memory window hit forwards when decode enabled
// - Upstream forwards outside windows when enabled
// - Prefetchable window compares full 64 bits
// - Prefetchable low nibbles read one
// - Capability pointer reads 40h
// - First capability word reads 8010h
// - Interrupt pin mirrors chipset pin setting
// - Interrupt line byte is plain storage
// - Bridge control bit 6 drives hot reset
// - VGA claim covers memory and I/O ranges
// - Alias suppress limits VGA to base ranges
// - ISA blocking refuses upper 768 bytes
// - Error messages forwarded only when enabled
// - Slot present bit is write-once
// - Device capabilities read 00000FC0h
// - Memory requests outside windows and VGA range master abort
// - Upstream cycles abort without bus master
module erpb_cfg (
	input  wire logic        CLK_I,
	input  wire logic        RESET_I,
	input  wire logic        CFG_WR_I,
	input  wire logic        CFG_RD_I,
	input  wire logic [7:0]  CFG_ADDR_I,
	input  wire logic [3:0]  CFG_BE_I,
	input  wire logic [31:0] CFG_WDATA_I,
	output logic      [31:0] CFG_RDATA_O,
	output logic             CFG_RVALID_O,
	input  wire logic [7:0]  PORT_IRQ_PIN_CFG_I,
	input  wire logic        MEM_DECODE_EN_I,
	input  wire logic        UPSTREAM_FWD_EN_I,
	input  wire logic        IO_WIN_HIT_I,
	input  wire logic        POISON_RX_I,
	input  wire logic        POISON_CPL_RX_I,
	input  wire logic        POISON_WR_TX_I,
	input  wire logic        UR_CPL_RX_I,
	input  wire logic        CA_CPL_RX_I,
	input  wire logic        CA_CPL_TX_I,
	input  wire logic        ERR_MSG_VALID_I,
	input  wire logic [1:0]  ERR_MSG_SEV_I,
	input  wire logic        DN_REQ_I,
	input  wire logic        DN_IS_IO_I,
	input  wire logic [63:0] DN_ADDR_I,
	input  wire logic        UP_REQ_I,
	input  wire logic [63:0] UP_ADDR_I,
	output logic             DN_FWD_O,
	output logic             DN_ABORT_O,
	output logic             UP_FWD_O,
	output logic             UP_ABORT_O,
	output logic             ERR_FWD_O,
	output logic      [1:0]  ERR_FWD_SEV_O,
	output logic             HOT_RESET_O
);
	// ****************************************
	// Storage
	// ****************************************
	logic [31:0]        mem_window;
	logic [31:0]        pref_window;
	logic [31:0]        pref_low_upper;
	logic [31:0]        pref_high_upper;
	logic [7:0]         irq_route_note;
	logic [15:0]        bridge_control;
	logic [31:0]        next_bctl_word;
	logic               slot_present;
	logic               slot_locked;
	logic [5:0]         flag_set;
	logic [5:0]         flag_clr;
	logic [5:0]         flags;
	logic [15:0]        stat_wr;
	logic [15:0]        downstream_status;
	logic [15:0]        express_cap;
	logic [31:0]        rd_word;
	logic               vga_mem;
	logic               vga_io;
	logic               isa_blk;
	logic               dn_claim;
	logic               dn_mem_hit;
	logic               up_win_hit;

	erpb_win_if mw ();
	erpb_win_if pw ();

	erpb_win u_mem_win (
		.w (mw)
	);

	erpb_win u_pref_win (
		.w (pw)
	);

	erpb_flags #(
		.N (erpb_pkg::FLG_N)
	) u_flags (
		.clk_i   (CLK_I),
		.rst_i   (RESET_I),
		.set_i   (flag_set),
		.clr_i   (flag_clr),
		.flags_o (flags)
	);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be, input logic [31:0] mask);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
		merge = (old & ~m) | (wd & m);
	endfunction : merge

	function automatic logic wr_at(input logic [5:0] dw);
		wr_at = CFG_WR_I && (CFG_ADDR_I[7:2] == dw);
	endfunction : wr_at

	function automatic logic in_rng(input logic [9:0] a, input logic [9:0] lo, input logic [9:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction : in_rng

	// ****************************************
	// Secondary status flags
	// ****************************************
	always_comb begin
		flag_set                    = '0;
		flag_set[erpb_pkg::FLG_PSRX] = POISON_RX_I;
		flag_set[erpb_pkg::FLG_ERRX] = ERR_MSG_VALID_I && (ERR_MSG_SEV_I != erpb_pkg::SEV_COR);
		flag_set[erpb_pkg::FLG_URRX] = UR_CPL_RX_I;
		flag_set[erpb_pkg::FLG_CARX] = CA_CPL_RX_I;
		flag_set[erpb_pkg::FLG_CATX] = CA_CPL_TX_I;
		flag_set[erpb_pkg::FLG_PPAR] = bridge_control[erpb_pkg::BC_PSNREP]
			&& (POISON_CPL_RX_I || POISON_WR_TX_I);
	end

	always_comb begin
		stat_wr  = wr_at(erpb_pkg::DW_DSTAT)
			? (CFG_WDATA_I[31:16] & {{8{CFG_BE_I[3]}}, {8{CFG_BE_I[2]}}}) : 16'h0000;
		flag_clr = {stat_wr[15], stat_wr[14], stat_wr[13], stat_wr[12], stat_wr[11], stat_wr[8]};
	end

	// Unlisted status bits stay zero
	assign downstream_status = {flags[erpb_pkg::FLG_PSRX], flags[erpb_pkg::FLG_ERRX],
		flags[erpb_pkg::FLG_URRX], flags[erpb_pkg::FLG_CARX], flags[erpb_pkg::FLG_CATX],
		2'h0, flags[erpb_pkg::FLG_PPAR], 8'h00};
	assign express_cap = erpb_pkg::XPCAP_RST | {7'h00, slot_present, 8'h00};
	// Bridge control sits in the upper half of its dword
	assign next_bctl_word = merge({bridge_control, 16'h0000}, CFG_WDATA_I, CFG_BE_I,
		{erpb_pkg::BRCTL_WMASK, 16'h0000});

	// ****************************************
	// Writable registers
	// ****************************************
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			mem_window      <= '0;
			pref_window     <= '0;
			pref_low_upper  <= '0;
			pref_high_upper <= '0;
		end else begin
			if (wr_at(erpb_pkg::DW_MWIN))
				mem_window <= merge(mem_window, CFG_WDATA_I, CFG_BE_I, erpb_pkg::WIN_WMASK);
			if (wr_at(erpb_pkg::DW_PWIN))
				pref_window <= merge(pref_window, CFG_WDATA_I, CFG_BE_I, erpb_pkg::WIN_WMASK);
			if (wr_at(erpb_pkg::DW_PLOUP))
				pref_low_upper <= merge(pref_low_upper, CFG_WDATA_I, CFG_BE_I, 32'hffffffff);
			if (wr_at(erpb_pkg::DW_PHIUP))
				pref_high_upper <= merge(pref_high_upper, CFG_WDATA_I, CFG_BE_I, 32'hffffffff);
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			irq_route_note <= 8'h00;
			bridge_control <= erpb_pkg::BRCTL_RST;
		end else if (wr_at(erpb_pkg::DW_IRQ)) begin
			if (CFG_BE_I[0])
				irq_route_note <= CFG_WDATA_I[7:0];
			bridge_control <= next_bctl_word[31:16];
		end
	end

	// Slot bit is captured once and kept until reset
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			slot_present <= 1'b0;
			slot_locked  <= 1'b0;
		end else if (wr_at(erpb_pkg::DW_CAPHD) && CFG_BE_I[3] && !slot_locked) begin
			slot_present <= CFG_WDATA_I[16 + erpb_pkg::XPCAP_SLOT];
			slot_locked  <= 1'b1;
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	always_comb begin
		case (CFG_ADDR_I[7:2])
			erpb_pkg::DW_DSTAT:  rd_word = {downstream_status, 16'h0000};
			erpb_pkg::DW_MWIN:   rd_word = mem_window;
			erpb_pkg::DW_PWIN:   rd_word = pref_window | erpb_pkg::PWIN_RO;
			erpb_pkg::DW_PLOUP:  rd_word = pref_low_upper;
			erpb_pkg::DW_PHIUP:  rd_word = pref_high_upper;
			erpb_pkg::DW_CAPPTR: rd_word = {24'h000000, erpb_pkg::CAPPTR_VAL};
			erpb_pkg::DW_IRQ:    rd_word = {bridge_control, PORT_IRQ_PIN_CFG_I, irq_route_note};
			erpb_pkg::DW_CAPHD:  rd_word = {express_cap, erpb_pkg::CAPHD_VAL};
			erpb_pkg::DW_DEVCAP: rd_word = erpb_pkg::DEVCAP_VAL;
			default:            rd_word = 32'h00000000;
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			CFG_RDATA_O  <= '0;
			CFG_RVALID_O <= 1'b0;
		end else begin
			CFG_RVALID_O <= CFG_RD_I;
			CFG_RDATA_O  <= CFG_RD_I ? rd_word : 32'h00000000;
		end
	end

	// ****************************************
	// Address decode
	// ****************************************
	assign mw.base    = {32'h00000000, mem_window[15:4]};
	assign mw.limit   = {32'h00000000, mem_window[31:20]};
	assign mw.addr_dn = DN_ADDR_I;
	assign mw.addr_up = UP_ADDR_I;
	assign pw.base    = {pref_low_upper, pref_window[15:4]};
	assign pw.limit   = {pref_high_upper, pref_window[31:20]};
	assign pw.addr_dn = DN_ADDR_I;
	assign pw.addr_up = UP_ADDR_I;

	always_comb begin
		dn_mem_hit = mw.hit_dn || pw.hit_dn;
		up_win_hit = mw.hit_up || pw.hit_up;
		vga_mem    = bridge_control[erpb_pkg::BC_VGA] && (DN_ADDR_I[63:17] == erpb_pkg::VGA_MEM_TAG);
		vga_io     = bridge_control[erpb_pkg::BC_VGA] && (DN_ADDR_I[63:16] == 48'h0)
			&& (!bridge_control[erpb_pkg::BC_NOALIAS] || (DN_ADDR_I[15:10] == 6'h00))
			&& (in_rng(DN_ADDR_I[9:0], erpb_pkg::VGA_IOA_LO, erpb_pkg::VGA_IOA_HI)
			|| in_rng(DN_ADDR_I[9:0], erpb_pkg::VGA_IOB_LO, erpb_pkg::VGA_IOB_HI));
		isa_blk    = bridge_control[erpb_pkg::BC_ISABLK] && (DN_ADDR_I[63:16] == 48'h0)
			&& (DN_ADDR_I[9:8] != 2'h0);
		dn_claim   = DN_IS_IO_I ? (vga_io || (IO_WIN_HIT_I && !isa_blk))
			: (vga_mem || (MEM_DECODE_EN_I && dn_mem_hit));
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			DN_FWD_O   <= 1'b0;
			DN_ABORT_O <= 1'b0;
		end else begin
			DN_FWD_O   <= DN_REQ_I && dn_claim;
			DN_ABORT_O <= DN_REQ_I && !dn_claim;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			UP_FWD_O   <= 1'b0;
			UP_ABORT_O <= 1'b0;
		end else begin
			UP_FWD_O   <= UP_REQ_I && UPSTREAM_FWD_EN_I && !up_win_hit;
			UP_ABORT_O <= UP_REQ_I && !(UPSTREAM_FWD_EN_I && !up_win_hit);
		end
	end

	// ****************************************
	// Error messages and hot reset
	// ****************************************
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			ERR_FWD_O     <= 1'b0;
			ERR_FWD_SEV_O <= 2'h0;
			HOT_RESET_O   <= 1'b0;
		end else begin
			ERR_FWD_O     <= ERR_MSG_VALID_I && bridge_control[erpb_pkg::BC_ERRFWD];
			ERR_FWD_SEV_O <= ERR_MSG_SEV_I;
			HOT_RESET_O   <= bridge_control[erpb_pkg::BC_HOTRST];
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);

	sequence s_rd(logic [5:0] dw);
		CFG_RD_I && (CFG_ADDR_I[7:2] == dw);
	endsequence

	property p_poison;
		POISON_RX_I |=> downstream_status[15];
	endproperty
	a_poison: assert property (p_poison) else $error("poison flag not set");

	property p_ppar_gate;
		$rose(flags[erpb_pkg::FLG_PPAR]) |-> $past(bridge_control[erpb_pkg::BC_PSNREP]);
	endproperty
	a_ppar_gate: assert property (p_ppar_gate) else $error("flag 8 set while disabled");

	property p_cap_ptr;
		s_rd(erpb_pkg::DW_CAPPTR) |=> CFG_RVALID_O && (CFG_RDATA_O == 32'h00000040);
	endproperty
	a_cap_ptr: assert property (p_cap_ptr) else $error("bad capability pointer");

	property p_dev_caps;
		s_rd(erpb_pkg::DW_DEVCAP) |=> CFG_RDATA_O == 32'h00000fc0;
	endproperty
	a_dev_caps: assert property (p_dev_caps) else $error("bad device caps");

	property p_mem_fwd;
		DN_REQ_I && !DN_IS_IO_I && MEM_DECODE_EN_I && mw.hit_dn |=> DN_FWD_O && !DN_ABORT_O;
	endproperty
	a_mem_fwd: assert property (p_mem_fwd) else $error("window hit not forwarded");

	property p_no_bm;
		UP_REQ_I && !UPSTREAM_FWD_EN_I |=> UP_ABORT_O && !UP_FWD_O;
	endproperty
	a_no_bm: assert property (p_no_bm) else $error("upstream forwarded without enable");

	property p_isa;
		DN_REQ_I && DN_IS_IO_I && isa_blk && !vga_io |=> !DN_FWD_O;
	endproperty
	a_isa: assert property (p_isa) else $error("ISA range forwarded");

	property p_err_drop;
		ERR_MSG_VALID_I && !bridge_control[erpb_pkg::BC_ERRFWD] |=> !ERR_FWD_O;
	endproperty
	a_err_drop: assert property (p_err_drop) else $error("error message not dropped");

	property p_slot_once;
		slot_locked |=> $stable(slot_present)[*2];
	endproperty
	a_slot_once: assert property (p_slot_once) else $error("slot bit changed twice");

	property p_hot_reset;
		CFG_WR_I && (CFG_ADDR_I[7:2] == erpb_pkg::DW_IRQ) && CFG_BE_I[2]
			|=> ##1 HOT_RESET_O == $past(CFG_WDATA_I[22], 2);
	endproperty
	a_hot_reset: assert property (p_hot_reset) else $error("hot reset not following bit");
endmodule : erpb_cfg

//--- erpb_far.sv
// Behavioural model of the attached device and backbone event sources
`timescale 1ns/1ps
module erpb_far (
	input  wire logic        clk_i,
	output logic             poison_rx_o,
	output logic             poison_cpl_o,
	output logic             poison_wr_o,
	output logic             ur_cpl_o,
	output logic             ca_rx_o,
	output logic             ca_tx_o,
	output logic             err_vld_o,
	output logic      [1:0]  err_sev_o,
	output logic             up_req_o,
	output logic      [63:0] up_addr_o
);
	initial begin
		{poison_rx_o, poison_cpl_o, poison_wr_o, ur_cpl_o, ca_rx_o, ca_tx_o, err_vld_o} = 7'h00;
		up_req_o = 1'b0;
		err_sev_o = 2'h3;
		up_addr_o = 64'h0;
	end
	// One-cycle event pulse; severity is scrambled outside the pulse
	task automatic pulse(input logic [6:0] m, input logic [1:0] sev);
		@(posedge clk_i);
		{poison_rx_o, poison_cpl_o, poison_wr_o, ur_cpl_o, ca_rx_o, ca_tx_o, err_vld_o} <= m;
		err_sev_o <= sev;
		@(posedge clk_i);
		{poison_rx_o, poison_cpl_o, poison_wr_o, ur_cpl_o, ca_rx_o, ca_tx_o, err_vld_o} <= 7'h00;
		err_sev_o <= ~sev;
	endtask : pulse
	// Memory request from the device; address is scrambled once released
	task automatic up_req(input logic [63:0] a);
		@(posedge clk_i);
		up_req_o <= 1'b1;
		up_addr_o <= a;
		@(posedge clk_i);
		up_req_o <= 1'b0;
		up_addr_o <= ~a;
	endtask : up_req
endmodule : erpb_far

//--- erpb_cfg_bench.sv
// Self-checking bench of the root port bridge configuration block
`timescale 1ns/1ps
module erpb_cfg_bench;
	logic        clk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0;
	logic [7:0]  cfg_addr = 8'h0, pin = 8'h0;
	logic [3:0]  cfg_be = 4'h0;
	logic [31:0] cfg_wdata = 32'h0, cfg_rdata, seed = 32'd38593;
	logic        cfg_rvalid, mem_en = 1'b0, up_en = 1'b0, io_hit = 1'b0;
	logic        dn_req = 1'b0, dn_io = 1'b0, dn_fwd, dn_abort, up_fwd, up_abort, err_fwd, hot_reset;
	logic [63:0] dn_addr = 64'h0, up_addr;
	logic        prx, pcpl, pwr, ur, carx, catx, evld, up_req;
	logic [1:0]  esev, err_fwd_sev;
	logic [31:0] rq[$], dq[$], uq[$], eq[$];
	int          compares = 0, miscompares = 0;
	logic [7:0]  ra[10] = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h34, 8'h40, 8'h44, 8'h30, 8'h48};
	logic [31:0] rv[10] = '{32'h0, 32'h0, 32'h00010001, 32'h0, 32'h0, 32'h40, 32'h00418010, 32'hfc0, 32'h0, 32'h0};
	logic [31:0] wv[10] = '{32'h0, 32'hfff0fff0, 32'hfff1fff1, 32'hffffffff, 32'hffffffff, 32'h40,
		32'h01418010, 32'hfc0, 32'h0, 32'h0};
	logic [15:0] fe[7] = '{16'h4000, 16'h0800, 16'h1000, 16'h2000, 16'h0000, 16'h0000, 16'h8000};
	always #50 clk = ~clk;
	erpb_far u_erpb_far (.clk_i(clk), .poison_rx_o(prx), .poison_cpl_o(pcpl), .poison_wr_o(pwr),
		.ur_cpl_o(ur), .ca_rx_o(carx), .ca_tx_o(catx), .err_vld_o(evld), .err_sev_o(esev),
		.up_req_o(up_req), .up_addr_o(up_addr));
	erpb_cfg u_erpb_cfg (.CLK_I(clk), .RESET_I(rst), .CFG_WR_I(cfg_wr), .CFG_RD_I(cfg_rd),
		.CFG_ADDR_I(cfg_addr), .CFG_BE_I(cfg_be), .CFG_WDATA_I(cfg_wdata), .CFG_RDATA_O(cfg_rdata),
		.CFG_RVALID_O(cfg_rvalid), .PORT_IRQ_PIN_CFG_I(pin), .MEM_DECODE_EN_I(mem_en),
		.UPSTREAM_FWD_EN_I(up_en), .IO_WIN_HIT_I(io_hit), .POISON_RX_I(prx), .POISON_CPL_RX_I(pcpl),
		.POISON_WR_TX_I(pwr), .UR_CPL_RX_I(ur), .CA_CPL_RX_I(carx), .CA_CPL_TX_I(catx),
		.ERR_MSG_VALID_I(evld), .ERR_MSG_SEV_I(esev), .DN_REQ_I(dn_req), .DN_IS_IO_I(dn_io),
		.DN_ADDR_I(dn_addr), .UP_REQ_I(up_req), .UP_ADDR_I(up_addr), .DN_FWD_O(dn_fwd),
		.DN_ABORT_O(dn_abort), .UP_FWD_O(up_fwd), .UP_ABORT_O(up_abort), .ERR_FWD_O(err_fwd),
		.ERR_FWD_SEV_O(err_fwd_sev), .HOT_RESET_O(hot_reset));
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk
	task automatic take(ref logic [31:0] q[$], input logic [31:0] g);
		if (q.size() == 0) begin
			miscompares++;
			$display("[ERR] t=%0t exp=none got=%h", $time, g);
		end else begin
			chk(q.pop_front(), g);
		end
	endtask : take
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge clk);
		cfg_wr <= 1'b1;
		cfg_addr <= a;
		cfg_be <= be;
		cfg_wdata <= d;
		@(posedge clk);
		cfg_wr <= 1'b0;
		cfg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		cfg_rd <= 1'b1;
		cfg_addr <= a;
		rq.push_back(e);
		@(posedge clk);
		cfg_rd <= 1'b0;
		cfg_addr <= ~a;
	endtask : rd
	task automatic bc(input logic [15:0] v);
		wr(8'h3c, 4'hc, {v, 16'h0});
	endtask : bc
	task automatic dn(input logic io, input logic [63:0] a, input logic f);
		@(posedge clk);
		dn_req <= 1'b1;
		dn_io <= io;
		dn_addr <= a;
		dq.push_back(f ? 32'h2 : 32'h1);
		@(posedge clk);
		dn_req <= 1'b0;
		dn_addr <= ~a;
	endtask : dn
	task automatic up(input logic [63:0] a, input logic f);
		uq.push_back(f ? 32'h2 : 32'h1);
		u_erpb_far.up_req(a);
	endtask : up
	task automatic test_done;
		if (rq.size() + dq.size() + uq.size() + eq.size() != 0)
			miscompares++;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	// ****************************************
	// Output monitor
	// ****************************************
	always @(negedge clk) begin
		if (!rst) begin
			if (cfg_rvalid !== 1'b0)
				take(rq, cfg_rdata);
			if ((dn_fwd | dn_abort) !== 1'b0)
				take(dq, {30'h0, dn_fwd, dn_abort});
			if ((up_fwd | up_abort) !== 1'b0)
				take(uq, {30'h0, up_fwd, up_abort});
			if (err_fwd !== 1'b0)
				take(eq, {30'h0, err_fwd_sev});
		end
	end
	initial begin
		repeat (4000) @(posedge clk);
		miscompares++;
		test_done;
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		seed = xs(seed);
		pin = seed[7:0];
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 10; i++)
			rd(ra[i], rv[i]);
		rd(8'h3c, {16'h0, pin, 8'h0});
		for (int i = 0; i < 10; i++) begin
			wr(ra[i], 4'hf, 32'hffffffff);
			rd(ra[i], wv[i]);
		end
		wr(8'h40, 4'hf, 32'h0);
		rd(8'h40, 32'h01418010);
		seed = xs(seed);
		wr(8'h28, 4'hf, seed);
		rd(8'h28, seed);
		wr(8'h3c, 4'hf, 32'hffffffff);
		seed = xs(seed);
		pin <= seed[7:0];
		rd(8'h3c, {16'h005f, seed[7:0], 8'hff});
		chk(32'h1, {31'h0, hot_reset});
		bc(16'h0);
		rd(8'h3c, {16'h0, seed[7:0], 8'hff});
		chk(32'h0, {31'h0, hot_reset});
		$display("done: registers");
		for (int p = 0; p < 2; p++) begin
			bc(p[15:0]);
			for (int i = 0; i < 7; i++) begin
				u_erpb_far.pulse(7'h01 << i, 2'h1);
				rd(8'h1c, {fe[i] | ((p == 1 && (i == 4 || i == 5)) ? 16'h0100 : 16'h0), 16'h0});
				wr(8'h1c, 4'hc, 32'hffff0000);
			end
		end
		u_erpb_far.pulse(7'h7f, 2'h2);
		wr(8'h1c, 4'hc, 32'h80000000);
		rd(8'h1c, 32'h79000000);
		fork
			wr(8'h1c, 4'hc, 32'h40000000);
			u_erpb_far.pulse(7'h01, 2'h1);
		join
		rd(8'h1c, 32'h79000000);
		wr(8'h1c, 4'hf, 32'hffffffff);
		u_erpb_far.pulse(7'h01, 2'h0);
		rd(8'h1c, 32'h0);
		bc(16'h0002);
		for (int s = 0; s < 3; s++) begin
			eq.push_back(s);
			u_erpb_far.pulse(7'h01, s[1:0]);
		end
		$display("done: flags and messages");
		wr(8'h20, 4'hf, 32'h1ff01000);
		wr(8'h24, 4'hf, 32'h00f00000);
		wr(8'h28, 4'hf, 32'h1);
		wr(8'h2c, 4'hf, 32'h1);
		bc(16'h0);
		@(posedge clk);
		mem_en <= 1'b1;
		up_en <= 1'b1;
		io_hit <= 1'b1;
		dn(0, 64'h10000000, 1);
		dn(0, 64'h1fffffff, 1);
		dn(0, 64'h0fffffff, 0);
		dn(0, 64'h20000000, 0);
		dn(0, 64'h110000000, 0);
		dn(0, 64'h100000000, 1);
		dn(0, 64'h100ffffff, 1);
		dn(0, 64'h101000000, 0);
		seed = xs(seed);
		dn(0, {36'h1, seed[27:0]}, 1);
		dn(1, 64'h100, 1);
		up(64'h0, 1);
		up(64'h10000000, 0);
		up(64'h100000000, 0);
		up(64'h30000000, 1);
		@(posedge clk);
		mem_en <= 1'b0;
		up_en <= 1'b0;
		io_hit <= 1'b0;
		dn(0, 64'h10000000, 0);
		dn(0, 64'ha0000, 0);
		up(64'h0, 0);
		bc(16'h0008);
		dn(0, 64'ha0000, 1);
		dn(0, 64'hbffff, 1);
		dn(0, 64'hc0000, 0);
		dn(1, 64'h3b0, 1);
		dn(1, 64'h3bb, 1);
		dn(1, 64'h3bc, 0);
		dn(1, 64'h3df, 1);
		dn(1, 64'h3e0, 0);
		dn(1, 64'hfbb0, 1);
		bc(16'h0018);
		dn(1, 64'h7b0, 0);
		dn(1, 64'h3c0, 1);
		bc(16'h0004);
		@(posedge clk);
		io_hit <= 1'b1;
		dn(1, 64'h0ff, 1);
		dn(1, 64'h100, 0);
		dn(1, 64'h7ff, 0);
		dn(1, 64'h400, 1);
		dn(1, 64'h10100, 1);
		$display("done: decode");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(8'h40, 32'h00418010);
		rd(8'h1c, 32'h0);
		rd(8'h3c, {16'h0, pin, 8'h0});
		repeat (3) @(posedge clk);
		$display("done: second reset");
		test_done;
	end
endmodule : erpb_cfg_bench
